/* File: common/power_ctl_pkg.sv */
// Constants and carrier types of the power mode and reset control block
package power_ctl_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS  = 10;   // Core clock period
	localparam int SPIKE_NS       = 10;   // Rejected reset pulse width
	// Samples of a low pin before it counts as a reset
	localparam int SPIKE_CYC      = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int SLEEP_EXIT_CYC = 1024; // Soft sleep exit delay
	localparam int STARTUP_CYC    = 1024; // Delay after a stable clock
	localparam int CMD_RUN_CYC    = 16;   // Length of a command run

	// ****************************************
	// Register indices, byte address is four times
	// ****************************************
	localparam logic [5:0] REG_RESERVED_IDX = 6'h00;
	localparam logic [5:0] REG_COMMAND_IDX  = 6'h01;
	localparam logic [5:0] REG_STATUS_IDX   = 6'h07;
	localparam logic [5:0] REG_PIN_IDX      = 6'h0D;
	localparam logic [5:0] REG_TXCTRL_IDX   = 6'h14;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int CMD_SLEEP_BIT = 4; // Soft sleep request
	localparam int CMD_ABORT_BIT = 5; // Write-only abort
	localparam int TX_EN1_BIT    = 0;
	localparam int TX_EN2_BIT    = 1;
	localparam logic [3:0] CMD_IDLE    = 4'h0;
	localparam logic [1:0] TX_RESET    = 2'h0;
	localparam logic [3:0] PIN_RESET   = 4'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// AXI4-Lite master to slave
	typedef struct packed {
		logic       awvalid;
		logic [7:0] awaddr;
		logic       wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic       bready;
		logic       arvalid;
		logic [7:0] araddr;
		logic       rready;
	} axiIn_t;

	// AXI4-Lite slave to master
	typedef struct packed {
		logic       awready;
		logic       wready;
		logic       bvalid;
		logic [1:0] bresp;
		logic       arready;
		logic       rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axiOut_t;

	typedef enum logic [1:0] {AWAKE, ASLEEP, WAKING} sleep_t;

endpackage

/* File: design/power_mode_reset_control.sv */
// Power mode, reset filter and register access control with AXI4-Lite slave
// Rules for this block and its host
// RQ1: Pin low enters hard down, oscillator off.
// RQ2: Hard down clamps inputs, freezes output pins.
// RQ3: Sleep request bit set enters sleep at once.
// RQ4: Sleep keeps inputs, outputs and registers intact.
// RQ5: Sleep ends 1024 clocks after writing zero.
// RQ6: Sleep bit reads one until exit clears it.
// RQ7: UART host should first send 55h.
// RQ8: Host polls address zero until it answers.
// RQ9: Either antenna enable zero kills the field.
// RQ10: Reset pulses under 10 ns are ignored.
// RQ11: Host holds reset low 100 ns minimum.
// RQ12: No access until 1024 cycles after clock.
// RQ13: Control bits change only by host writes.
// RQ14: Command field also updated by hardware.
// RQ15: Read-only bits ignore host writes.
// RQ16: Write-only bits always read zero.
// RQ17: Host leaves reserved locations unchanged.
// RQ18: Unaddressable after release until startup delay.
module power_mode_reset_control
	import power_ctl_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  reset_n,
	input  wire logic                  reset_soft_sleep_request_bit_n_pin,
	input  wire logic                  oscStable,
	input  wire logic [3:0]            pinIn,
	input  wire power_ctl_pkg::axiIn_t axiIn,
	output power_ctl_pkg::axiOut_t     axiOut,
	output logic                       oscEnable,
	output logic [3:0]                 pinOut,
	output logic                       antennaDrive1,
	output logic                       antennaDrive2,
	output logic                       rfFieldOn
);
	import power_ctl_pkg::*;

	// ****************************************
	// Reset release
	// ****************************************
	logic rstSync1_r;   // First stage, read only by stage two
	logic rstN;         // Released reset copy
	// Two flops so release is clean
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstSync1_r <= 1'b0;
			rstN       <= 1'b0;
		end else begin
			rstSync1_r <= 1'b1;
			rstN       <= rstSync1_r;
		end
	end

	// ****************************************
	// Reset pin spike filter
	// ****************************************
	logic [SPIKE_CYC-1:0] pinLow_r;  // Recent low samples
	logic                 hardDown;  // Filtered hard power-down
	// A single low sample is a spike, not a reset
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			pinLow_r <= '0;
			hardDown <= 1'b0;
		end else begin
			pinLow_r <= {pinLow_r[SPIKE_CYC-2:0], ~reset_soft_sleep_request_bit_n_pin};
			if (reset_soft_sleep_request_bit_n_pin) begin
				hardDown <= 1'b0;
			end else if (&pinLow_r) begin
				hardDown <= 1'b1; // RQ10
			end
		end
	end

	// ****************************************
	// Startup delay
	// ****************************************
	logic [10:0] startCnt_r;  // Cycles of stable clock
	logic        ready;       // Device may be addressed
	assign ready = (startCnt_r == 11'(STARTUP_CYC));
	// Restarts whenever hard down cuts the oscillator
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			startCnt_r <= '0;
		end else if (hardDown || !oscStable) begin
			startCnt_r <= '0; // RQ18
		end else if (!ready) begin
			startCnt_r <= startCnt_r + 11'd1; // RQ12
		end
	end

	// ****************************************
	// Bus slave
	// ****************************************
	logic        awHeld_r;   // Write address taken
	logic        wHeld_r;    // Write data taken
	logic [5:0]  wIdx_r;     // Write register index
	logic [7:0]  wByte_r;    // Write low byte
	logic        wLane_r;    // Low byte lane enabled
	logic        doWrite;    // Write happens this cycle
	logic        bValid_r;
	logic [1:0]  bResp_r;
	logic        rValid_r;
	logic [31:0] rData_r;
	logic [1:0]  rResp_r;
	logic [7:0]  readVal;    // Decoded read data
	logic        readHit;    // Read index is mapped
	logic        writeHit;   // Write index is mapped
	assign axiOut.awready = !awHeld_r && !bValid_r;
	assign axiOut.wready  = !wHeld_r && !bValid_r;
	assign axiOut.arready = !rValid_r;
	assign axiOut.bvalid  = bValid_r;
	assign axiOut.bresp   = bResp_r;
	assign axiOut.rvalid  = rValid_r;
	assign axiOut.rdata   = rData_r;
	assign axiOut.rresp   = rResp_r;
	assign doWrite = awHeld_r && wHeld_r && !bValid_r;
	assign writeHit = (wIdx_r == REG_RESERVED_IDX) || (wIdx_r == REG_COMMAND_IDX)
		|| (wIdx_r == REG_STATUS_IDX) || (wIdx_r == REG_PIN_IDX)
		|| (wIdx_r == REG_TXCTRL_IDX);
	// Address and data may arrive in either order
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			awHeld_r <= 1'b0;
			wHeld_r  <= 1'b0;
			wIdx_r   <= '0;
			wByte_r  <= '0;
			wLane_r  <= 1'b0;
			bValid_r <= 1'b0;
			bResp_r  <= RESP_OKAY;
		end else begin
			if (axiIn.awvalid && axiOut.awready) begin
				awHeld_r <= 1'b1;
				wIdx_r   <= axiIn.awaddr[7:2];
			end
			if (axiIn.wvalid && axiOut.wready) begin
				wHeld_r <= 1'b1;
				wByte_r <= axiIn.wdata[7:0];
				wLane_r <= axiIn.wstrb[0];
			end
			if (doWrite) begin
				awHeld_r <= 1'b0;
				wHeld_r  <= 1'b0;
				bValid_r <= 1'b1;
				// Refused until startup delay has run
				bResp_r  <= (ready && writeHit) ? RESP_OKAY : RESP_SLVERR; // RQ12
			end else if (bValid_r && axiIn.bready) begin
				bValid_r <= 1'b0;
			end
		end
	end
	// Write strobes per register, only once addressable
	logic wrOk;
	logic cmdWr;
	logic pinWr;
	logic txWr;
	assign wrOk  = doWrite && ready && wLane_r;
	assign cmdWr = wrOk && (wIdx_r == REG_COMMAND_IDX);
	assign pinWr = wrOk && (wIdx_r == REG_PIN_IDX);
	assign txWr  = wrOk && (wIdx_r == REG_TXCTRL_IDX);

	// ****************************************
	// Soft sleep
	// ****************************************
	sleep_t      sleepState;
	logic [9:0]  wakeCnt_r;   // Exit delay counter
	logic        sleeping;    // Request bit as read back
	assign sleeping = (sleepState != AWAKE); // RQ6
	// Writing zero only starts the exit; bit stays set
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			sleepState <= AWAKE;
			wakeCnt_r  <= '0;
		end else if (hardDown) begin
			sleepState <= AWAKE;
			wakeCnt_r  <= '0;
		end else begin
			case (sleepState)
				AWAKE: begin
					if (cmdWr && wByte_r[CMD_SLEEP_BIT]) begin
						sleepState <= ASLEEP; // RQ3
					end
				end
				ASLEEP: begin
					if (cmdWr && !wByte_r[CMD_SLEEP_BIT]) begin
						sleepState <= WAKING; // RQ6
						wakeCnt_r  <= '0;
					end
				end
				WAKING: begin
					// A new request cancels the exit
					if (cmdWr && wByte_r[CMD_SLEEP_BIT]) begin
						sleepState <= ASLEEP;
					end else if (wakeCnt_r == 10'(SLEEP_EXIT_CYC - 1)) begin
						sleepState <= AWAKE; // RQ5
					end else begin
						wakeCnt_r <= wakeCnt_r + 10'd1;
					end
				end
				default: begin
					sleepState <= AWAKE;
				end
			endcase
		end
	end
	// Oscillator off in either power-down
	assign oscEnable = !hardDown && !sleeping; // RQ1

	// ****************************************
	// Command field
	// ****************************************
	logic [3:0] command_r;   // Dynamic command field
	logic [3:0] runCnt_r;    // Command run time
	// Host write beats completion in the same cycle
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			command_r <= CMD_IDLE;
			runCnt_r  <= '0;
		end else if (hardDown) begin
			command_r <= CMD_IDLE;
			runCnt_r  <= '0;
		end else if (cmdWr) begin
			command_r <= wByte_r[CMD_ABORT_BIT] ? CMD_IDLE : wByte_r[3:0];
			runCnt_r  <= '0;
		end else if (command_r != CMD_IDLE && !sleeping) begin
			// Paused while asleep, so contents are retained
			if (runCnt_r == 4'(CMD_RUN_CYC - 1)) begin
				command_r <= CMD_IDLE; // RQ14
			end else begin
				runCnt_r <= runCnt_r + 4'd1;
			end
		end
	end

	// ****************************************
	// Control bits and pins
	// ****************************************
	logic [1:0] txCtrl_r;   // Antenna driver enables
	logic [3:0] pinReg_r;   // Output pin values
	logic [3:0] pinSeen_r;  // Sampled inputs
	// Only host writes alter these
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			txCtrl_r <= TX_RESET;
			pinReg_r <= PIN_RESET;
		end else if (!hardDown) begin
			if (txWr) begin
				txCtrl_r <= wByte_r[1:0]; // RQ13
			end
			if (pinWr) begin
				pinReg_r <= wByte_r[3:0]; // RQ13
			end
		end
	end
	// Inputs clamped low in hard down; outputs frozen
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			pinSeen_r <= '0;
			pinOut    <= PIN_RESET;
		end else if (hardDown) begin
			pinSeen_r <= '0; // RQ2
		end else begin
			pinSeen_r <= pinIn; // RQ4
			pinOut    <= pinReg_r;
		end
	end
	// Either enable low powers the transmitter down
	assign antennaDrive1 = txCtrl_r[TX_EN1_BIT] && txCtrl_r[TX_EN2_BIT] && !hardDown; // RQ9
	assign antennaDrive2 = antennaDrive1;
	assign rfFieldOn     = antennaDrive1;

	// ****************************************
	// Read path
	// ****************************************
	// Abort bit reads zero; status ignores writes
	always_comb begin
		readVal = 8'h00;
		readHit = 1'b1;
		case (axiIn.araddr[7:2])
			REG_RESERVED_IDX: readVal = 8'h00;
			REG_COMMAND_IDX:  readVal = {3'b000, sleeping, command_r}; // RQ16
			REG_STATUS_IDX:   readVal = {3'b000, ready, command_r != CMD_IDLE,
				!antennaDrive1, sleepState == WAKING, sleeping}; // RQ15
			REG_PIN_IDX:      readVal = {pinSeen_r, pinReg_r};
			REG_TXCTRL_IDX:   readVal = {6'b000000, txCtrl_r};
			default:          readHit = 1'b0;
		endcase
	end
	// Reads answer one cycle after the address is taken
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			rValid_r <= 1'b0;
			rData_r  <= '0;
			rResp_r  <= RESP_OKAY;
		end else if (axiIn.arvalid && axiOut.arready) begin
			rValid_r <= 1'b1;
			rData_r  <= (ready && readHit) ? {24'h000000, readVal} : 32'h00000000;
			rResp_r  <= (ready && readHit) ? RESP_OKAY : RESP_SLVERR; // RQ8
		end else if (rValid_r && axiIn.rready) begin
			rValid_r <= 1'b0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	hardOscOff_a: assert property (@(posedge core_clk) disable iff (!rstN) // RQ1
		hardDown |-> !oscEnable && !rfFieldOn) else $error("oscillator on in hard down");
	inputClamp_a: assert property (@(posedge core_clk) disable iff (!rstN) // RQ2
		hardDown |=> pinSeen_r == 4'h0) else $error("inputs not clamped");
	pinFreeze_a: assert property (@(posedge core_clk) disable iff (!rstN) // RQ2
		hardDown ##1 hardDown |-> $stable(pinOut)) else $error("pins moved in hard down");
	sleepEnter_a: assert property (@(posedge core_clk) disable iff (!rstN) // RQ3
		cmdWr && wByte_r[CMD_SLEEP_BIT] && !hardDown |=> sleeping && !oscEnable)
		else $error("sleep not entered");
	sleepHold_a: assert property (@(posedge core_clk) disable iff (!rstN) // RQ5
		$rose(sleepState == WAKING) && !hardDown |-> sleeping [*8])
		else $error("sleep left early");
	sleepExit_a: assert property (@(posedge core_clk) disable iff (!rstN) // RQ6
		sleepState == WAKING && wakeCnt_r == 10'(SLEEP_EXIT_CYC - 1) && !cmdWr
		&& !hardDown |=> !sleeping) else $error("sleep bit not cleared");
	txRetain_a: assert property (@(posedge core_clk) disable iff (!rstN) // RQ13
		!txWr |=> $stable(txCtrl_r)) else $error("control bits changed");
	txOff_a: assert property (@(posedge core_clk) disable iff (!rstN) // RQ9
		!txCtrl_r[TX_EN1_BIT] || !txCtrl_r[TX_EN2_BIT] |-> !rfFieldOn)
		else $error("field on with driver disabled");
	spikeFilter_a: assert property (@(posedge core_clk) disable iff (!rstN) // RQ10
		$rose(hardDown) |-> !$past(reset_soft_sleep_request_bit_n_pin) && !$past(reset_soft_sleep_request_bit_n_pin, 2))
		else $error("spike caused reset");
	startBlock_a: assert property (@(posedge core_clk) disable iff (!rstN) // RQ12
		axiIn.arvalid && axiOut.arready && !ready |=> rResp_r == RESP_SLVERR)
		else $error("read accepted before startup");
	writeOnly_a: assert property (@(posedge core_clk) disable iff (!rstN) // RQ16
		axiIn.arvalid && axiOut.arready && axiIn.araddr[7:2] == REG_COMMAND_IDX
		|=> !rData_r[CMD_ABORT_BIT]) else $error("write-only bit read back");

endmodule // power_mode_reset_control

/* File: tb/host_model.sv */
// Host side model: AXI4-Lite master tasks and the start-up poll
module host_model
	import power_ctl_pkg::*;
(
	input  wire logic                   core_clk,
	input  wire power_ctl_pkg::axiOut_t axiOut,
	output power_ctl_pkg::axiIn_t       axiIn,
	output logic                        hung
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****
	// Bus idle at time zero
	// ****
	initial begin
		axiIn = '0;
		hung = 1'b0;
	end

	// One write; each channel drops right after the edge that takes it
	task automatic write(input logic [5:0] idx, input logic [7:0] val, output logic [1:0] resp);
		int n;
		resp = 2'h3;
		@(posedge core_clk);
		axiIn.awvalid <= 1'b1;
		axiIn.awaddr <= {idx, 2'b00};
		axiIn.wvalid <= 1'b1;
		axiIn.wdata <= {24'h000000, val};
		axiIn.wstrb <= 4'hF;
		axiIn.bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge core_clk);
			resp = axiOut.bresp;
			if (axiIn.awvalid && axiOut.awready) axiIn.awvalid <= 1'b0;
			if (axiIn.wvalid && axiOut.wready) axiIn.wvalid <= 1'b0;
			if (axiOut.bvalid) break;
		end
		axiIn.bready <= 1'b0;
		// A lost answer ends the run rather than hanging it
		if (n == 64) hung = 1'b1;
	endtask

	// One read, answer taken at the edge where rvalid is seen
	task automatic read(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp);
		int n;
		resp = 2'h3;
		d = '1;
		@(posedge core_clk);
		axiIn.arvalid <= 1'b1;
		axiIn.araddr <= {idx, 2'b00};
		axiIn.rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge core_clk);
			d = axiOut.rdata;
			resp = axiOut.rresp;
			if (axiIn.arvalid && axiOut.arready) axiIn.arvalid <= 1'b0;
			if (axiOut.rvalid) break;
		end
		axiIn.rready <= 1'b0;
		if (n == 64) hung = 1'b1;
	endtask

	// Keep reading the reserved word until the device answers OKAY
	task automatic poll_ready();
		logic [31:0] d;
		logic [1:0]  r;
		int          k;
		for (k = 0; k < 600; k++) begin
			read(REG_RESERVED_IDX, d, r);
			if (r === RESP_OKAY) break;
		end
		if (k == 600) hung = 1'b1;
	endtask
endmodule // host_model

/* File: tb/tb_top.sv */
// Testbench top: register sequences for power modes, reset filter and bit classes
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import power_ctl_pkg::*;

	logic        core_clk;             // Core clock
	logic        reset_n = 1'b0;       // Block reset
	logic        pinN = 1'b1;          // Hard down pin, idle high
	logic        oscStable = 1'b1;     // Oscillator stable
	logic [3:0]  pinIn = 4'hA;         // Digital inputs
	axiIn_t      axiIn;                // Host to block
	axiOut_t     axiOut;               // Block to host
	logic        oscEnable;
	logic [3:0]  pinOut;
	logic        drv1;
	logic        drv2;
	logic        rfOn;
	logic        hung;                 // Host wait ran out
	int          cyc = 0;              // Free cycle count
	int          n_errors = 0;
	int          num_checks = 0;

	// ****
	// Clock, cycle count and hang trap
	// ****
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) cyc <= cyc + 1;
	always @(posedge hung) begin
		n_errors++;
		report_and_stop();
	end

	power_mode_reset_control u_power_mode_reset_control (.core_clk(core_clk),
		.reset_n(reset_n), .reset_soft_sleep_request_bit_n_pin(pinN), .oscStable(oscStable),
		.pinIn(pinIn), .axiIn(axiIn), .axiOut(axiOut), .oscEnable(oscEnable),
		.pinOut(pinOut), .antennaDrive1(drv1), .antennaDrive2(drv2), .rfFieldOn(rfOn));

	host_model u_host_model (.core_clk(core_clk), .axiOut(axiOut), .axiIn(axiIn), .hung(hung));

	// ****
	// Shared helpers
	// ****
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// Write, then let outputs settle before anyone looks
	task automatic wr(input logic [5:0] i, input logic [7:0] v);
		logic [1:0] r;
		u_host_model.write(i, v, r);
		@(negedge core_clk);
	endtask

	task automatic rdc(input string what, input logic [5:0] i, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		u_host_model.read(i, d, r);
		check(what, d, e);
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ****
	// Main sequence
	// ****
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          t0;
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		t0 = cyc;
		// Internal reset lifts two edges later; a request before that is lost
		repeat (2) @(posedge core_clk);
		// Start-up: first byte 55h, refused like any access before the delay
		u_host_model.write(REG_PIN_IDX, 8'h55, r);
		check("early wr resp", r, RESP_SLVERR);
		u_host_model.read(REG_STATUS_IDX, d, r);
		check("early resp", r, RESP_SLVERR);
		check("early data", d, 32'h0);
		u_host_model.poll_ready();
		check("startup", (cyc - t0 >= 1024) && (cyc - t0 < 1050), 1);
		rdc("pin early", REG_PIN_IDX, 32'hA0);
		rdc("status", REG_STATUS_IDX, 32'h14);
		wr(REG_STATUS_IDX, 8'hFF);
		rdc("status ro", REG_STATUS_IDX, 32'h14);
		wr(REG_RESERVED_IDX, 8'h00);
		rdc("reserved", REG_RESERVED_IDX, 32'h0);
		u_host_model.read(6'h3F, d, r);
		check("unmapped resp", r, RESP_SLVERR);
		// Either driver enable low keeps the field off
		for (int k = 0; k < 4; k++) begin
			wr(REG_TXCTRL_IDX, 8'(k));
			check("field", rfOn, k == 3);
			check("drivers", {drv1, drv2}, {2{k == 3}});
			rdc("txctrl", REG_TXCTRL_IDX, k);
		end
		wr(REG_PIN_IDX, 8'hF5);
		check("pinOut", pinOut, 4'h5);
		rdc("pin reg", REG_PIN_IDX, 32'hA5);
		// Command field runs, then hardware returns it to idle
		wr(REG_COMMAND_IDX, 8'h03);
		rdc("cmd run", REG_COMMAND_IDX, 32'h03);
		repeat (20) @(negedge core_clk);
		rdc("cmd done", REG_COMMAND_IDX, 32'h0);
		wr(REG_COMMAND_IDX, 8'h03);
		wr(REG_COMMAND_IDX, 8'h20);
		rdc("abort", REG_COMMAND_IDX, 32'h0);
		// Soft sleep in and out
		wr(REG_COMMAND_IDX, 8'h10);
		check("sleep osc", oscEnable, 1'b0);
		check("sleep pins", pinOut, 4'h5);
		rdc("sleep tx", REG_TXCTRL_IDX, 32'h3);
		wr(REG_COMMAND_IDX, 8'h00);
		rdc("sleep bit", REG_COMMAND_IDX, 32'h10);
		// Exit lands on the 1024th edge after the write edge
		repeat (1020) @(negedge core_clk);
		check("still asleep", oscEnable, 1'b0);
		repeat (1) @(negedge core_clk);
		check("awake", oscEnable, 1'b1);
		rdc("sleep clear", REG_COMMAND_IDX, 32'h0);
		// A single low sample is a spike
		@(posedge core_clk);
		pinN <= 1'b0;
		@(posedge core_clk);
		pinN <= 1'b1;
		@(negedge core_clk);
		check("spike osc", oscEnable, 1'b1);
		rdc("spike status", REG_STATUS_IDX, 32'h10);
		// Long low pulse: hard down, outputs frozen
		@(posedge core_clk);
		pinN <= 1'b0;
		pinIn <= 4'h3;
		repeat (10) @(posedge core_clk);
		@(negedge core_clk);
		check("hard osc", oscEnable, 1'b0);
		check("hard field", rfOn, 1'b0);
		check("hard pins", pinOut, 4'h5);
		@(posedge core_clk);
		pinN <= 1'b1;
		t0 = cyc;
		u_host_model.read(REG_STATUS_IDX, d, r);
		check("wake resp", r, RESP_SLVERR);
		u_host_model.poll_ready();
		check("wake delay", cyc - t0 >= 1024, 1);
		rdc("tx held", REG_TXCTRL_IDX, 32'h3);
		rdc("pin held", REG_PIN_IDX, 32'h35);
		// Clock loses stability: the start-up delay begins again
		@(posedge core_clk);
		oscStable <= 1'b0;
		repeat (5) @(posedge core_clk);
		oscStable <= 1'b1;
		t0 = cyc;
		u_host_model.read(REG_STATUS_IDX, d, r);
		check("unstable resp", r, RESP_SLVERR);
		u_host_model.poll_ready();
		check("restable delay", (cyc - t0 >= 1024) && (cyc - t0 < 1050), 1);
		report_and_stop();
	end
endmodule // tb_top
